// [core/fdu_pkg.sv]
// fault dispatch unit constants, codes and state encoding
package fdu_pkg;
   // return-type field code marking a fault call
   localparam logic [2:0]  RT_FAULT      = 3'h1;
   // fault type numbers the unit can raise, plus reserved FT_FLOAT_RSVD, which it rejects
   localparam logic [15:0] FT_TRACE      = 16'h0001;
   localparam logic [15:0] FT_OPERATION  = 16'h0002;
   localparam logic [15:0] FT_ARITH      = 16'h0003;
   localparam logic [15:0] FT_FLOAT_RSVD = 16'h0004;
   localparam logic [15:0] FT_CONSTRAINT = 16'h0005;
   localparam logic [15:0] FT_PROTECTION = 16'h0007;
   localparam logic [15:0] FT_TYPE       = 16'h000a;
   // numeric subtypes
   localparam logic [7:0]  FS_ONE        = 8'h01;
   localparam logic [7:0]  FS_TWO        = 8'h02;
   localparam logic [7:0]  FS_OP_MAX     = 8'h04;
   // bit-position subtypes: trace uses bits 1..7, protection length is bit 1
   localparam logic [7:0]  FS_TRACE_MASK = 8'hfe;
   localparam logic [7:0]  FS_PROT_LEN   = 8'h02;
   // fault table entry layout
   localparam logic [1:0]  ENT_LOCAL     = 2'h0;
   localparam logic [1:0]  ENT_SYSTEM    = 2'h2;
   localparam logic [31:0] ENT_SYS_WORD1 = 32'h0000027f;
   localparam logic [31:0] ENT_BYTES     = 32'h00000008;
   localparam logic [31:0] WORD_BYTES    = 32'h00000004;
   // system procedure table: first procedure entry and supervisor entry type
   localparam logic [31:0] SPT_ENTRY_OFS = 32'h00000030;
   localparam logic [1:0]  SPT_SUPER     = 2'h2;
   // fault record placement
   localparam logic [31:0] ALIGN_ADD     = 32'h0000000f;
   localparam logic [31:0] ALIGN_MASK    = 32'hfffffff0;
   localparam logic [31:0] REC_BYTES     = 32'h00000050;
   localparam logic [31:0] REC_OFS_PC    = 32'h00000040;
   localparam logic [31:0] REC_OFS_AC    = 32'h00000044;
   localparam logic [31:0] REC_OFS_CODE  = 32'h00000048;
   localparam logic [31:0] REC_OFS_IP    = 32'h0000004c;
   localparam logic [1:0]  REC_LAST      = 2'h3;
   // sequencer states, one-hot
   typedef enum logic [7:0] {
      ST_IDLE = 8'h01,
      ST_SAVE = 8'h02,
      ST_ENT0 = 8'h04,
      ST_ENT1 = 8'h08,
      ST_SPT  = 8'h10,
      ST_WREC = 8'h20,
      ST_RLD  = 8'h40,
      ST_ERR  = 8'h80
   } fdu_state_t;
endpackage : fdu_pkg

// [core/fdu_code_map.sv]
// fault type and subtype legality check and record word packing
`timescale 1ns/10ps
module fdu_code_map
   import fdu_pkg::*;
(
   // fault identification in
   input  wire logic [15:0] fault_type,
   input  wire logic [7:0]  fault_subtype,
   // packed record word and legality
   output logic [31:0]      code_word,
   output logic             code_legal
);
   // type in the upper half, subtype in the lower half
   assign code_word = {fault_type, 8'h00, fault_subtype};   // [RULE_14] [RULE_12]

   // only the documented pairs pass; reserved types never get through
   always_comb begin
      code_legal = 1'b0;
      case (fault_type)
         FT_TRACE:      code_legal = (fault_subtype != 8'h00) &&
                                     ((fault_subtype & ~FS_TRACE_MASK) == 8'h00); // [RULE_13]
         FT_OPERATION:  code_legal = (fault_subtype >= FS_ONE) &&
                                     (fault_subtype <= FS_OP_MAX);                // [RULE_15]
         FT_ARITH:      code_legal = (fault_subtype == FS_ONE) ||
                                     (fault_subtype == FS_TWO);                   // [RULE_16]
         FT_CONSTRAINT: code_legal = (fault_subtype == FS_ONE);                   // [RULE_17]
         FT_PROTECTION: code_legal = (fault_subtype == FS_PROT_LEN);              // [RULE_17]
         FT_TYPE:       code_legal = (fault_subtype == FS_ONE);                   // [RULE_17]
         default:       code_legal = 1'b0;                                        // [RULE_18]
      endcase
   end
endmodule : fdu_code_map

// [core/fdu_core.sv]
// fault dispatch sequencer: register save, table walk, record write, return
`timescale 1ns/10ps
// Contract
// [RULE_01] on fault, find type, handler, call it
// [RULE_02] call is local, system-local or system-supervisor
// [RULE_03] first save local registers to cache
// [RULE_04] previous frame pointer gets frame pointer, type 001
// [RULE_05] user-mode supervisor call switches stack, else realign
// [RULE_06] write fault record onto selected stack
// [RULE_07] handler address from fault or system table
// [RULE_08] frame on user/supervisor stack, interrupt when interrupted
// [RULE_09] recoverable fault resumes at return address
// [RULE_10] faults accepted in program, interrupt or fault handler
// [RULE_11] same entry for nested interrupt and fault cases
// [RULE_12] record type and subtype, index by type
// [RULE_13] subtype eight bits, trace uses bit positions
// [RULE_14] type upper half, subtype lower half
// [RULE_15] operation faults type 2, subtypes 1 to 4
// [RULE_16] arithmetic faults type 3, overflow and divide
// [RULE_17] constraint, protection and type mismatch codes
// [RULE_18] reserved types never generated
// [RULE_19] system table route allows supervisor execution
// [RULE_20] entry two words, type bits, system word 027f
// [RULE_21] round to 16 bytes, reserve 80 bytes
// [RULE_22] fault return restores process and arithmetic state
module fdu_core
   import fdu_pkg::*;
(
   // clock and reset
   input  wire logic        ref_clk,
   input  wire logic        rst_n,
   // fault request from execution
   input  wire logic        fault_req,
   input  wire logic [15:0] fault_type,
   input  wire logic [7:0]  fault_subtype,
   input  wire logic [31:0] fault_ip,
   output logic             fault_ack,
   // processor context at the fault
   input  wire logic [31:0] frame_pointer,
   input  wire logic [31:0] stack_pointer,
   input  wire logic [31:0] super_stack_pointer,
   input  wire logic [31:0] proc_ctrl,
   input  wire logic [31:0] arith_ctrl,
   input  wire logic        user_mode,
   input  wire logic        interrupted,
   // table bases
   input  wire logic [31:0] fault_table_base,
   input  wire logic [31:0] sys_table_base,
   // fault return request
   input  wire logic        ret_req,
   input  wire logic [31:0] ret_prev_frame,
   input  wire logic [31:0] ret_frame_pointer,
   input  wire logic [31:0] ret_return_ip,
   // local register cache
   output logic             cache_save,
   input  wire logic        cache_ack,
   // memory word port
   output logic             mem_req,
   output logic             mem_we,
   output logic [31:0]      mem_addr,
   output logic [31:0]      mem_wdata,
   input  wire logic [31:0] mem_rdata,
   input  wire logic        mem_ack,
   // call results
   output logic             call_done,
   output logic             call_error,
   output logic [31:0]      handler_ip,
   output logic [31:0]      new_frame_pointer,
   output logic [31:0]      new_stack_pointer,
   output logic [31:0]      prev_frame_pointer,
   output logic             handler_super,
   // return results
   output logic             resume,
   output logic [31:0]      instruction_pointer,
   output logic [31:0]      restored_pc,
   output logic [31:0]      restored_ac,
   output logic             busy
);
   // all sequencer state in one record
   typedef struct packed {
      fdu_state_t  state;     // sequencer state
      logic [1:0]  cnt;       // record word counter
      logic [31:0] code;      // packed type and subtype
      logic [31:0] fip;       // faulting instruction address
      logic [31:0] pc;        // captured process controls
      logic [31:0] ac;        // captured arithmetic controls
      logic [31:0] fp;        // captured frame pointer
      logic [31:0] sp;        // captured current stack pointer
      logic [31:0] ssp;       // captured supervisor stack pointer
      logic        umode;     // captured user mode
      logic        intr;      // captured interrupted state
      logic [15:0] ftype;     // captured type for table index
      logic [31:0] e0;        // first entry word
      logic [31:0] rb;        // record base on the new stack
      logic        sup;       // handler runs supervisor
      logic        cache;     // cache push request
      logic        mreq;      // memory request
      logic        mwe;       // memory write
      logic [31:0] maddr;     // memory address
      logic [31:0] mwdata;    // memory write data
      logic        done;      // call taken pulse
      logic        err;       // bad code or entry pulse
      logic [31:0] hip;       // handler address
      logic [31:0] nfp;       // new frame pointer
      logic [31:0] nsp;       // new stack pointer
      logic [31:0] pfp;       // previous frame pointer
      logic        rsm;       // resume pulse
      logic [31:0] rip;       // resume address
      logic [31:0] rpc;       // restored process controls
      logic [31:0] rac;       // restored arithmetic controls
   } fdu_st_t;

   fdu_st_t     st_ff;        // registered state
   fdu_st_t     nxt_st;       // next state
   logic [31:0] code_word;    // packed record word
   logic        code_legal;   // request names a known fault
   logic [31:0] sel_sp;       // stack chosen for the handler
   logic [31:0] rec_base;     // aligned record base

   // code packing and legality live apart so they can be reused by trace logic
   fdu_code_map u_code_map (
      .fault_type    (fault_type),
      .fault_subtype (fault_subtype),
      .code_word     (code_word),
      .code_legal    (code_legal)
   );

   // stack choice: supervisor stack only for a supervisor call out of user mode;
   // when interrupted the current stack already is the interrupt stack;
   // reads the registered call kind so the choice never loops through nxt_st
   always_comb begin
      sel_sp = st_ff.sp;                                           // [RULE_08]
      if (st_ff.sup && st_ff.umode && !st_ff.intr) begin
         sel_sp = st_ff.ssp;                                       // [RULE_05]
      end
      rec_base = (sel_sp + ALIGN_ADD) & ALIGN_MASK;                // [RULE_21]
   end

   // sequencer next state
   always_comb begin
      nxt_st      = st_ff;
      nxt_st.done = 1'b0;
      nxt_st.err  = 1'b0;
      nxt_st.rsm  = 1'b0;
      case (st_ff.state)
         ST_IDLE: begin
            // a fault is taken whatever the processor is running
            if (fault_req) begin                                   // [RULE_10] [RULE_11]
               nxt_st.code  = code_word;                           // [RULE_12]
               nxt_st.ftype = fault_type;
               nxt_st.fip   = fault_ip;
               nxt_st.pc    = proc_ctrl;
               nxt_st.ac    = arith_ctrl;
               nxt_st.fp    = frame_pointer;
               nxt_st.sp    = stack_pointer;
               nxt_st.ssp   = super_stack_pointer;
               nxt_st.umode = user_mode;
               nxt_st.intr  = interrupted;
               nxt_st.sup   = 1'b0;
               nxt_st.cache = 1'b1;                                // [RULE_03]
               nxt_st.state = code_legal ? ST_SAVE : ST_ERR;       // [RULE_18]
            end else if (ret_req && ret_prev_frame[2:0] == RT_FAULT) begin
               // fault return: pull saved controls out of the record
               nxt_st.rb    = ret_frame_pointer - REC_BYTES;       // [RULE_22]
               nxt_st.rip   = ret_return_ip;                       // [RULE_09]
               nxt_st.cnt   = 2'h0;
               nxt_st.mreq  = 1'b1;
               nxt_st.mwe   = 1'b0;
               nxt_st.maddr = ret_frame_pointer - REC_BYTES + REC_OFS_PC;
               nxt_st.state = ST_RLD;
            end
         end
         ST_SAVE: begin
            // no table access until the register set is safely cached
            if (cache_ack) begin
               nxt_st.cache = 1'b0;
               nxt_st.pfp   = {st_ff.fp[31:3], RT_FAULT};          // [RULE_04]
               nxt_st.mreq  = 1'b1;
               nxt_st.mwe   = 1'b0;
               nxt_st.maddr = fault_table_base +
                              ({16'h0000, st_ff.ftype} * ENT_BYTES); // [RULE_12] [RULE_01]
               nxt_st.state = ST_ENT0;
            end
         end
         ST_ENT0: begin
            if (mem_ack) begin
               nxt_st.e0    = mem_rdata;
               nxt_st.maddr = st_ff.maddr + WORD_BYTES;            // [RULE_20]
               nxt_st.state = ST_ENT1;
            end
         end
         ST_ENT1: begin
            if (mem_ack) begin
               if (st_ff.e0[1:0] == ENT_LOCAL) begin
                  // plain local call: handler address in the entry itself
                  nxt_st.hip   = {st_ff.e0[31:2], 2'h0};           // [RULE_02] [RULE_07]
                  nxt_st.mreq  = 1'b0;
                  nxt_st.state = ST_WREC;
               end else if (st_ff.e0[1:0] == ENT_SYSTEM &&
                            mem_rdata == ENT_SYS_WORD1) begin      // [RULE_20]
                  nxt_st.maddr = sys_table_base + SPT_ENTRY_OFS +
                                 {st_ff.e0[31:2], 2'h0};           // [RULE_07]
                  nxt_st.state = ST_SPT;
               end else begin
                  // reserved entry types stop the walk rather than guess
                  nxt_st.mreq  = 1'b0;
                  nxt_st.state = ST_ERR;
               end
            end
         end
         ST_SPT: begin
            if (mem_ack) begin
               nxt_st.hip   = {mem_rdata[31:2], 2'h0};             // [RULE_07]
               nxt_st.sup   = (mem_rdata[1:0] == SPT_SUPER);       // [RULE_02] [RULE_19]
               nxt_st.mreq  = 1'b0;
               nxt_st.state = ST_WREC;
            end
         end
         ST_WREC: begin
            // first cycle here fixes the stack, then four record words go out
            if (!st_ff.mwe) begin
               nxt_st.rb     = rec_base;
               nxt_st.nsp    = sel_sp;                             // [RULE_05]
               nxt_st.nfp    = rec_base + REC_BYTES;               // [RULE_21]
               nxt_st.cnt    = 2'h0;
               nxt_st.mreq   = 1'b1;
               nxt_st.mwe    = 1'b1;
               nxt_st.maddr  = rec_base + REC_OFS_PC;              // [RULE_06]
               nxt_st.mwdata = st_ff.pc;
            end else if (mem_ack) begin
               nxt_st.cnt = st_ff.cnt + 2'h1;
               case (st_ff.cnt)
                  2'h0: begin
                     nxt_st.maddr  = st_ff.rb + REC_OFS_AC;
                     nxt_st.mwdata = st_ff.ac;
                  end
                  2'h1: begin
                     nxt_st.maddr  = st_ff.rb + REC_OFS_CODE;
                     nxt_st.mwdata = st_ff.code;                   // [RULE_14]
                  end
                  2'h2: begin
                     nxt_st.maddr  = st_ff.rb + REC_OFS_IP;
                     nxt_st.mwdata = st_ff.fip;
                  end
                  default: begin
                     nxt_st.mreq  = 1'b0;
                     nxt_st.mwe   = 1'b0;
                     nxt_st.done  = 1'b1;                          // [RULE_01]
                     nxt_st.state = ST_IDLE;
                  end
               endcase
            end
         end
         ST_RLD: begin
            if (mem_ack) begin
               if (st_ff.cnt == 2'h0) begin
                  nxt_st.rpc   = mem_rdata;                        // [RULE_22]
                  nxt_st.cnt   = 2'h1;
                  nxt_st.maddr = st_ff.rb + REC_OFS_AC;
               end else begin
                  nxt_st.rac   = mem_rdata;                        // [RULE_22]
                  nxt_st.mreq  = 1'b0;
                  nxt_st.rsm   = 1'b1;                             // [RULE_09]
                  nxt_st.state = ST_IDLE;
               end
            end
         end
         ST_ERR: begin
            nxt_st.cache = 1'b0;
            nxt_st.err   = 1'b1;
            nxt_st.state = ST_IDLE;
         end
         default: nxt_st.state = ST_IDLE;
      endcase
   end

   // state register; synchronous reset returns the sequencer to idle
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         st_ff       <= '0;
         st_ff.state <= ST_IDLE;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // outputs straight from the state record, except fault_ack, which also gates fault_req directly
   assign fault_ack           = (st_ff.state == ST_IDLE) && fault_req;
   assign busy                = (st_ff.state != ST_IDLE);
   assign cache_save          = st_ff.cache;
   assign mem_req             = st_ff.mreq;
   assign mem_we              = st_ff.mwe;
   assign mem_addr            = st_ff.maddr;
   assign mem_wdata           = st_ff.mwdata;
   assign call_done           = st_ff.done;
   assign call_error          = st_ff.err;
   assign handler_ip          = st_ff.hip;
   assign new_frame_pointer   = st_ff.nfp;
   assign new_stack_pointer   = st_ff.nsp;
   assign prev_frame_pointer  = st_ff.pfp;
   assign handler_super       = st_ff.sup;
   assign resume              = st_ff.rsm;
   assign instruction_pointer = st_ff.rip;
   assign restored_pc         = st_ff.rpc;
   assign restored_ac         = st_ff.rac;

   // checks
   sequence s_entry_read;
      st_ff.state == ST_ENT1 && mem_ack;
   endsequence

   a_save_first: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (st_ff.state == ST_SAVE) |-> cache_save && !mem_req)                       // [RULE_03]
      else $error("memory touched before register save");
   a_pfp_type: assert property (@(posedge ref_clk) disable iff (!rst_n)
      $rose(st_ff.state == ST_ENT0) |-> prev_frame_pointer[2:0] == 3'h1)         // [RULE_04]
      else $error("return type not fault call");
   a_table_index: assert property (@(posedge ref_clk) disable iff (!rst_n)
      $rose(st_ff.state == ST_ENT0) |->
         mem_addr == fault_table_base + ({16'h0000, st_ff.ftype} << 3))          // [RULE_12]
      else $error("fault table index wrong");
   a_align_rec: assert property (@(posedge ref_clk) disable iff (!rst_n)
      call_done |-> new_frame_pointer[3:0] == 4'h0 &&
                    new_frame_pointer - new_stack_pointer >= 32'h50 &&
                    new_frame_pointer - new_stack_pointer <= 32'h5f)             // [RULE_21]
      else $error("record not aligned or sized");
   a_bad_sysword: assert property (@(posedge ref_clk) disable iff (!rst_n)
      s_entry_read ##0 (st_ff.e0[1:0] == 2'h2 && mem_rdata != 32'h0000027f)
         |=> st_ff.state == ST_ERR ##1 call_error)                              // [RULE_20]
      else $error("bad system entry accepted");
   a_stack_switch: assert property (@(posedge ref_clk) disable iff (!rst_n)
      call_done && handler_super && st_ff.umode && !st_ff.intr |->
         new_stack_pointer == st_ff.ssp)                                         // [RULE_05]
      else $error("supervisor stack not taken");
   a_stay_stack: assert property (@(posedge ref_clk) disable iff (!rst_n)
      call_done && (st_ff.intr || !handler_super) |->
         new_stack_pointer == st_ff.sp)                                          // [RULE_08]
      else $error("stack changed without supervisor call");
   a_code_word: assert property (@(posedge ref_clk) disable iff (!rst_n)
      mem_req && mem_we && mem_addr == st_ff.rb + 32'h48 |->
         mem_wdata == st_ff.code)                                                // [RULE_14]
      else $error("record code word wrong");
   a_reserved: assert property (@(posedge ref_clk) disable iff (!rst_n)
      fault_ack && (fault_type == 16'h4 || fault_type == 16'h6) |=>
         st_ff.state == ST_ERR)                                                  // [RULE_18]
      else $error("reserved fault type dispatched");
   a_resume_ip: assert property (@(posedge ref_clk) disable iff (!rst_n)
      resume |-> instruction_pointer == $past(st_ff.rip))                        // [RULE_09]
      else $error("resume address lost");
endmodule : fdu_core

// [sim/fdu_core_bench.sv]
// self-checking bench for the fault dispatch sequencer
`timescale 1ns/10ps
module fdu_core_bench;
   import fdu_pkg::*;
   typedef struct packed {logic [15:0] ty; logic [7:0] st; logic ok;} fdu_row_t;
   logic        ref_clk, rst_n, fault_req, fault_ack, user_mode, interrupted, ret_req;
   logic [15:0] fault_type;
   logic [7:0]  fault_subtype;
   logic        cache_save, cache_ack, mem_req, mem_we, mem_ack, call_done, call_error;
   logic        handler_super, resume, busy;
   logic [31:0] fault_ip, frame_pointer, stack_pointer, super_stack_pointer, proc_ctrl;
   logic [31:0] arith_ctrl, fault_table_base, sys_table_base, ret_prev_frame;
   logic [31:0] ret_frame_pointer, ret_return_ip, mem_addr, mem_wdata, mem_rdata;
   logic [31:0] handler_ip, new_frame_pointer, new_stack_pointer, prev_frame_pointer;
   logic [31:0] instruction_pointer, restored_pc, restored_ac, ent0, ent1, spt;
   logic [31:0] wmem [logic [31:0]];   // record words written by the unit
   int          n_mismatch = 0;
   int          cmp_count = 0;
   // legal and illegal codes; the illegal ones must end in an error pulse
   fdu_row_t rows [15] = '{
      '{16'h0001, 8'h02, 1'b1}, '{16'h0001, 8'h80, 1'b1}, '{16'h0002, 8'h01, 1'b1},
      '{16'h0002, 8'h03, 1'b1}, '{16'h0002, 8'h04, 1'b1}, '{16'h0003, 8'h01, 1'b1},
      '{16'h0003, 8'h02, 1'b1}, '{16'h0005, 8'h01, 1'b1}, '{16'h0007, 8'h02, 1'b1},
      '{16'h000a, 8'h01, 1'b1}, '{16'h0004, 8'h01, 1'b0}, '{16'h0006, 8'h01, 1'b0},
      '{16'h0001, 8'h01, 1'b0}, '{16'h0002, 8'h05, 1'b0}, '{16'h000b, 8'h01, 1'b0}};
   fdu_core dut (.ref_clk(ref_clk), .rst_n(rst_n), .fault_req(fault_req),
      .fault_type(fault_type), .fault_subtype(fault_subtype), .fault_ip(fault_ip),
      .fault_ack(fault_ack), .frame_pointer(frame_pointer), .stack_pointer(stack_pointer),
      .super_stack_pointer(super_stack_pointer), .proc_ctrl(proc_ctrl),
      .arith_ctrl(arith_ctrl), .user_mode(user_mode), .interrupted(interrupted),
      .fault_table_base(fault_table_base), .sys_table_base(sys_table_base),
      .ret_req(ret_req), .ret_prev_frame(ret_prev_frame),
      .ret_frame_pointer(ret_frame_pointer), .ret_return_ip(ret_return_ip),
      .cache_save(cache_save), .cache_ack(cache_ack), .mem_req(mem_req), .mem_we(mem_we),
      .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
      .mem_ack(mem_ack), .call_done(call_done), .call_error(call_error),
      .handler_ip(handler_ip), .new_frame_pointer(new_frame_pointer),
      .new_stack_pointer(new_stack_pointer), .prev_frame_pointer(prev_frame_pointer),
      .handler_super(handler_super), .resume(resume),
      .instruction_pointer(instruction_pointer), .restored_pc(restored_pc),
      .restored_ac(restored_ac), .busy(busy));
   // clock, 50 ns period
   initial begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end
   // memory contents: fault table page, system table page, else address-derived
   function automatic logic [31:0] lookup(input logic [31:0] a);
      if (a[31:12] == 20'h00001) return a[2] ? ent1 : ent0;
      if (a[31:12] == 20'h00002) return spt;
      return a ^ 32'h5a5a0000;
   endfunction : lookup
   // data bus shows the inverse outside an ack so stale values never match
   always_comb mem_rdata = mem_ack ? lookup(mem_addr) : ~lookup(mem_addr);
   // one-cycle acks from memory and register cache
   always @(negedge ref_clk) begin
      mem_ack <= mem_req && !mem_ack && rst_n;
      cache_ack <= cache_save && !cache_ack && rst_n;
   end
   // capture record writes at the accepting edge
   always @(posedge ref_clk) begin
      if (mem_ack && mem_req && mem_we) wmem[mem_addr] = mem_wdata;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic tally_and_finish();
      if (n_mismatch == 0 && cmp_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : tally_and_finish
   // raise one fault at a falling edge and wait for its outcome
   task automatic run_fault(input logic [15:0] ty, input logic [7:0] st);
      int n;
      fault_type = ty;
      fault_subtype = st;
      fault_req = 1'b1;
      #1 chk({31'h0, fault_ack}, 32'h1);
      @(negedge ref_clk);
      fault_req = 1'b0;
      chk({31'h0, cache_save}, 32'h1);
      n = 0;
      while (call_done !== 1'b1 && call_error !== 1'b1 && n < 80) begin
         @(negedge ref_clk);
         n++;
      end
   endtask : run_fault
   // watchdog: the whole sequence needs well under a thousand cycles
   initial begin
      #(50 * 5000);
      n_mismatch++;
      tally_and_finish();
   end
   initial begin
      {rst_n, fault_req, user_mode, interrupted, ret_req, mem_ack, cache_ack} = '0;
      {fault_type, fault_subtype, proc_ctrl, arith_ctrl, ret_prev_frame} = '0;
      {ret_frame_pointer, ret_return_ip} = '0;
      fault_ip = 32'h00000300; frame_pointer = 32'h00004004; stack_pointer = 32'h00006003;
      super_stack_pointer = 32'h00007001; proc_ctrl = 32'h00000011;
      arith_ctrl = 32'h00000022; fault_table_base = 32'h00001000;
      sys_table_base = 32'h00002000; ent0 = 32'h00a00100; ent1 = '0; spt = '0;
      repeat (3) @(negedge ref_clk);
      chk({30'h0, busy, call_done}, 32'h0);
      rst_n = 1'b1;
      // local entry, every row of codes
      foreach (rows[i]) begin
         run_fault(rows[i].ty, rows[i].st);
         if (rows[i].ok) begin
            chk({31'h0, call_done}, 32'h1);
            chk(wmem[32'h00006058], {rows[i].ty, 8'h00, rows[i].st});
            chk(handler_ip, 32'h00a00100);
            chk(prev_frame_pointer, 32'h00004001);
            chk(new_frame_pointer, 32'h00006060);
            chk(wmem[32'h00006050], proc_ctrl);
            chk(wmem[32'h0000605c], fault_ip);
         end else begin
            chk({30'h0, call_error, call_done}, 32'h2);
         end
         @(negedge ref_clk);
      end
      // system-supervisor call from user mode switches stacks
      user_mode = 1'b1; ent0 = 32'h00000012; ent1 = ENT_SYS_WORD1; spt = 32'h00000902;
      run_fault(FT_TRACE, 8'h04);
      chk(handler_ip, 32'h00000900);
      chk({31'h0, handler_super}, 32'h1);
      chk(new_stack_pointer, super_stack_pointer);
      chk(wmem[32'h00007058], 32'h00010004);
      // interrupted state stays on the interrupt stack
      interrupted = 1'b1;
      run_fault(FT_ARITH, FS_TWO);
      chk(new_stack_pointer, stack_pointer);
      // system-local call keeps the current stack
      interrupted = 1'b0; spt = 32'h00000900;
      run_fault(FT_ARITH, FS_ONE);
      chk({31'h0, handler_super}, 32'h0);
      chk(new_stack_pointer, stack_pointer);
      // wrong second word, then a reserved entry type
      ent1 = 32'h0000027e;
      run_fault(FT_ARITH, FS_ONE);
      chk({31'h0, call_error}, 32'h1);
      ent0 = 32'h00000011; ent1 = ENT_SYS_WORD1;
      run_fault(FT_ARITH, FS_ONE);
      chk({31'h0, call_error}, 32'h1);
      // fault return restores state and resumes
      ret_prev_frame = 32'h00004001; ret_frame_pointer = 32'h00008050;
      ret_return_ip = 32'h0000abc0; ret_req = 1'b1;
      @(negedge ref_clk);
      ret_req = 1'b0;
      for (int n = 0; n < 40 && resume !== 1'b1; n++) @(negedge ref_clk);
      chk({31'h0, resume}, 32'h1);
      chk(restored_pc, 32'h5a5a8040);
      chk(restored_ac, 32'h5a5a8044);
      chk(instruction_pointer, ret_return_ip);
      // a plain return type is not taken
      ret_prev_frame = 32'h00004002; ret_req = 1'b1;
      repeat (3) @(negedge ref_clk);
      chk({31'h0, busy}, 32'h0);
      ret_req = 1'b0;
      tally_and_finish();
   end
endmodule : fdu_core_bench
